// >>> core/dbws_main.sv
// dbws_main: dual bank wake sequencer with its serial register port
// assumes: pins are asynchronous, serial clock well below clock_i/4,
// msg_rx_i comes from the receiver logic on clock_i
`timescale 1ns/10ps
`include "dbws_cfg.svh"
module dbws_main
  import dbws_pkg::*;
#(
  parameter int TICK_CYC = `DBWS_TICK_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wake_pin_i,
  input wire logic wake_float_i,
  input wire logic cfg_sel_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic msg_rx_i,
  output logic spi_miso_o,
  output dbws_state_t dev_state_o,
  output logic bank_status_o,
  output dbws_cfg1_t band_ctrl_o
);
  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic wake;
  logic flt;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic [2:0] bits;
  logic [2:0] next_bits;
  logic [7:0] sh_in;
  logic [7:0] next_sh_in;
  logic [7:0] sh_out;
  logic [7:0] next_sh_out;
  logic [4:0] addr;
  logic [4:0] next_addr;
  logic is_cmd;
  logic next_is_cmd;
  logic wr;
  logic next_wr;
  logic [3:0] left;
  logic [3:0] next_left;
  logic wr_en;
  logic spi_done;
  dbws_bank_t bank_a;
  dbws_bank_t next_bank_a;
  dbws_bank_t bank_b;
  dbws_bank_t next_bank_b;
  logic status;
  logic next_status;
  logic soft_rst;
  logic next_soft_rst;
  dbws_state_t sched;
  dbws_state_t next_sched;
  dbws_state_t sched_st;
  dbws_state_t dev;
  dbws_state_t next_dev;
  dbws_cfg1_t next_band;
  logic osc;
  logic alt;
  logic only_b;
  logic forced_high;
  logic forced_low;
  logic wake_fall;
  logic tmr_done;
  logic tmr_restart;
  logic [3:0] units;

  // -------------------------------------------------------------
  // pin synchronisers; levels come from the second stage, edges compare the second and third stages
  // -------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 5'h10;
      sync2 <= 5'h10;
      sync3 <= 5'h10;
    end else if (ce_i) begin
      sync1 <= {cfg_sel_n_i, spi_mosi_i, spi_sclk_i, wake_float_i,
                wake_pin_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign wake = sync2[0];
  assign flt = sync2[1];
  assign sclk_rise = ~sync3[2] & sync2[2];
  assign sclk_fall = sync3[2] & ~sync2[2];
  assign cs_fall = sync3[4] & ~sync2[4];
  assign cs_rise = ~sync3[4] & sync2[4];
  assign wake_fall = sync3[0] & ~wake;

  // -------------------------------------------------------------
  // mode decode
  // -------------------------------------------------------------
  assign osc = bank_a.cfg2[`DBWS_OSCEN_BIT];
  assign alt = bank_a.seq[`DBWS_SEQ_SEL_BIT] &
               bank_b.seq[`DBWS_SEQ_SEL_BIT];
  assign only_b = ~bank_a.seq[`DBWS_SEQ_SEL_BIT] &
                  bank_b.seq[`DBWS_SEQ_SEL_BIT];
  // a floating pin only hands control over in oscillator mode
  assign forced_high = wake & ~(osc & flt);
  assign forced_low = ~wake & ~(osc & flt);

  // -------------------------------------------------------------
  // register read mux, status shared by both banks
  // -------------------------------------------------------------
  function automatic logic [7:0] rd_reg(input logic [4:0] a);
    dbws_bank_t b;
    b = a[`DBWS_BANK_BIT] ? bank_b : bank_a;
    if (a[3:0] == `DBWS_REG_CFG1) begin
      rd_reg = b.cfg1;
    end else if (a[3:0] == `DBWS_REG_CFG2) begin
      rd_reg = b.cfg2;
    end else if (a[3:0] == `DBWS_REG_CMD) begin
      rd_reg = {b.cmd_hi, status};
    end else if (a[3:0] == `DBWS_REG_SEQ) begin
      rd_reg = b.seq;
    end else begin
      rd_reg = 8'h00;
    end
  endfunction : rd_reg

  // -------------------------------------------------------------
  // serial slave: command byte then up to 2^N data bytes
  // -------------------------------------------------------------
  // bytes are taken on the eighth falling edge; a partial byte
  // at deselect is simply dropped
  always_comb begin
    next_bits = bits;
    next_sh_in = sh_in;
    next_sh_out = sh_out;
    next_addr = addr;
    next_is_cmd = is_cmd;
    next_wr = wr;
    next_left = left;
    wr_en = 1'b0;
    spi_done = cs_rise & ~is_cmd;
    if (cs_fall) begin
      next_bits = 3'h0;
      next_is_cmd = 1'b1;
      next_left = 4'h0;
    end else if (~sync2[4]) begin
      if (sclk_rise) begin
        next_sh_in = {sh_in[6:0], sync2[3]};
      end
      if (sclk_fall) begin
        next_bits = 3'(bits + 3'h1);
        next_sh_out = {sh_out[6:0], 1'b0};
        if (bits == 3'h7) begin
          if (is_cmd) begin
            next_is_cmd = 1'b0;
            next_wr = sh_in[`DBWS_CMD_WR_BIT];
            next_addr = sh_in[`DBWS_CMD_A_HI:0];
            next_left = 4'h1 << sh_in[`DBWS_CMD_N_HI:`DBWS_CMD_N_LO];
            next_sh_out = rd_reg(sh_in[`DBWS_CMD_A_HI:0]);
          end else if (left != 4'h0) begin
            wr_en = wr;
            next_left = 4'(left - 4'h1);
            next_addr = 5'(addr + 5'h01);
            next_sh_out = rd_reg(5'(addr + 5'h01));
          end
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bits <= 3'h0;
      sh_in <= 8'h00;
      sh_out <= 8'h00;
      addr <= 5'h00;
      is_cmd <= 1'b1;
      wr <= 1'b0;
      left <= 4'h0;
    end else if (ce_i) begin
      bits <= next_bits;
      sh_in <= next_sh_in;
      sh_out <= next_sh_out;
      addr <= next_addr;
      is_cmd <= next_is_cmd;
      wr <= next_wr;
      left <= next_left;
    end
  end

  assign spi_miso_o = sh_out[7];

  // -------------------------------------------------------------
  // register banks, bank status and global reset
  // -------------------------------------------------------------
  always_comb begin
    dbws_bank_t wb;
    wb = addr[`DBWS_BANK_BIT] ? bank_b : bank_a;
    next_bank_a = bank_a;
    next_bank_b = bank_b;
    next_status = status;
    next_soft_rst = 1'b0;
    if (soft_rst) begin
      // global reset reloads defaults, which also clears its bit
      next_bank_a = {`DBWS_CFG1_RST, `DBWS_CFG2_RST, `DBWS_CMDH_RST,
                     `DBWS_SEQ_RST};
      next_bank_b = next_bank_a;
      next_status = `DBWS_STATUS_RST;
    end else begin
      if (wr_en) begin
        if (addr[3:0] == `DBWS_REG_CFG1) begin
          wb.cfg1 = sh_in;
          next_soft_rst = sh_in[`DBWS_GRST_BIT];
        end else if (addr[3:0] == `DBWS_REG_CFG2) begin
          wb.cfg2 = sh_in;
        end else if (addr[3:0] == `DBWS_REG_CMD) begin
          wb.cmd_hi = sh_in[7:1]; // status bit is read only
        end else if (addr[3:0] == `DBWS_REG_SEQ) begin
          wb.seq = sh_in;
        end
        if (addr[`DBWS_BANK_BIT]) begin
          next_bank_b = wb;
        end else begin
          next_bank_a = wb;
        end
      end
      if (spi_done) begin
        next_status = 1'b1;
      end else if (!alt) begin
        next_status = ~only_b & 1'b1;
        if (!bank_b.seq[`DBWS_SEQ_SEL_BIT]) begin
          next_status = 1'b1;
        end
      end else if (!osc) begin
        if (wake_fall) begin
          next_status = ~status;
        end
      end else if (tmr_done && sched != ST_OFF && !forced_high) begin
        next_status = ~status;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bank_a <= {`DBWS_CFG1_RST, `DBWS_CFG2_RST, `DBWS_CMDH_RST,
                 `DBWS_SEQ_RST};
      bank_b <= {`DBWS_CFG1_RST, `DBWS_CFG2_RST, `DBWS_CMDH_RST,
                 `DBWS_SEQ_RST};
      status <= `DBWS_STATUS_RST;
      soft_rst <= 1'b0;
    end else if (ce_i) begin
      bank_a <= next_bank_a;
      bank_b <= next_bank_b;
      status <= next_status;
      soft_rst <= next_soft_rst;
    end
  end

  // -------------------------------------------------------------
  // free-running schedule and device state
  // -------------------------------------------------------------
  // the schedule never waits for the pin or a message, so a
  // stretched state leaves the later ones on their own grid
  always_comb begin
    if (sched == ST_OFF) begin
      sched_st = ST_OFF;
    end else if (alt) begin
      sched_st = sched;
    end else begin
      sched_st = only_b ? ST_B : ST_A;
    end
    if (sched_st == ST_B) begin
      units = bank_b.seq[`DBWS_SEQ_ON_HI:`DBWS_SEQ_ON_LO];
    end else if (sched_st == ST_A) begin
      units = bank_a.seq[`DBWS_SEQ_ON_HI:`DBWS_SEQ_ON_LO];
    end else begin
      units = {1'b0, bank_a.seq[`DBWS_SEQ_OFF_HI:`DBWS_SEQ_OFF_LO]};
    end
    next_sched = sched;
    tmr_restart = 1'b0;
    if (soft_rst || spi_done || !osc) begin
      next_sched = ST_A;
      tmr_restart = 1'b1;
    end else if (tmr_done) begin
      tmr_restart = 1'b1;
      if (sched == ST_OFF) begin
        next_sched = ST_A;
      end else if (sched == ST_A && alt) begin
        next_sched = ST_B;
      end else begin
        next_sched = ST_OFF;
      end
    end
    next_dev = dev;
    if (soft_rst) begin
      next_dev = ST_OFF;
    end else if (msg_rx_i && dev != ST_OFF) begin
      next_dev = dev;
    end else if (forced_high) begin
      next_dev = status ? ST_A : ST_B;
    end else if (forced_low) begin
      next_dev = ST_OFF;
    end else begin
      next_dev = sched_st;
    end
    next_band = (dev == ST_B) ? bank_b.cfg1 : bank_a.cfg1;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sched <= ST_A;
      dev <= ST_OFF;
      band_ctrl_o <= `DBWS_CFG1_RST;
    end else if (ce_i) begin
      sched <= next_sched;
      dev <= next_dev;
      band_ctrl_o <= next_band;
    end
  end

  assign dev_state_o = dev;
  assign bank_status_o = status;

  dbws_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .restart_i(tmr_restart),
    .units_i(units),
    .done_o(tmr_done)
  );

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_access_end;
    ce_i && spi_done;
  endsequence
  sequence s_grst;
    ce_i && soft_rst;
  endsequence

  status_a_a: assert property (
    ce_i && !bank_b.seq[`DBWS_SEQ_SEL_BIT] |=> status)
    else $error("status not 1 with only bank A");
  status_b_a: assert property (
    ce_i && !soft_rst && !spi_done && only_b |=> !status)
    else $error("status not 0 with only bank B");
  off_low_a: assert property (
    ce_i && !soft_rst && forced_low && !msg_rx_i |=> dev == ST_OFF)
    else $error("device not off with pin low");
  msg_hold_a: assert property (
    ce_i && !soft_rst && msg_rx_i && dev != ST_OFF |=> $stable(dev))
    else $error("state left during message");
  pin_toggle_a: assert property (
    ce_i && !soft_rst && !spi_done && alt && !osc && wake_fall
    |=> status != $past(status))
    else $error("status missed pin falling edge");
  spi_restart_a: assert property (
    s_access_end |=> status && sched == ST_A)
    else $error("sequence not restarted at bank A");
  osc_toggle_a: assert property (
    ce_i && !soft_rst && !spi_done && alt && osc && tmr_done &&
    sched != ST_OFF && !forced_high |=> status != $past(status))
    else $error("status missed end of on state");
  force_hold_a: assert property (
    ce_i && !soft_rst && forced_high && !(msg_rx_i && dev != ST_OFF)
    |=> dev == ($past(status) ? ST_A : ST_B) && $stable(status))
    else $error("forced high did not hold status bank");
  sched_follow_a: assert property (
    ce_i && !soft_rst && !forced_high && !forced_low &&
    !(msg_rx_i && dev != ST_OFF) |=> dev == $past(sched_st))
    else $error("device off the schedule grid");
  grst_clear_a: assert property (
    s_grst |=> !soft_rst && bank_a.cfg1 == `DBWS_CFG1_RST)
    else $error("global reset did not reload and clear");
endmodule : dbws_main

// >>> core/dbws_cfg.svh
// dbws_cfg.svh: constants of the dual bank wake sequencer
// assumes: included by every design module
// Function
// - pin-driven switching when the MCU drives the wake pin and osc enable is 0
// - select bits: B clear gives A, A0/B1 gives B, both alternate (receive only)
// - only bank A selected and pin high: run bank A, status bit reads 1
// - only bank B selected and pin high: run bank B, status bit reads 0
// - pin low with no message in reception puts the device OFF
// - a message in reception holds bank-A or bank-B state until it ends
// - pin mode, both banks: status picks the bank, toggles on pin falling edge
// - after any serial access the next sequence starts with bank-A state
// - osc-driven switching applies when the wake osc enable bit is 1
// - osc mode: a driven pin overrides, a floating pin leaves the oscillator in charge
// - osc mode, both banks: status toggles at end of each on state: A, B, OFF
// - osc mode, pin forced high: hold the bank the status shows, no alternation
// - A on time from bank A, B on time from bank B, OFF from bank A
// - pin high: ON in the status bank until release and message end
// - pin released from low during OFF: the begun OFF period runs to its end
// - stretching one state does not shift the timing of later states
// - every register is readable and writable over the serial slave port
// - reset loads every register with its default value
// - first config register: bands, carrier, global reset, polarity, detect, clock; 0x91
// - writing 1 to global reset resets registers and counters, bit self-clears
// - the status bit reads the same from both banks
`ifndef DBWS_CFG_SVH
`define DBWS_CFG_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DBWS_CLK_MHZ 25
`define DBWS_TICK_US 100
`define DBWS_TICK_CYC (`DBWS_TICK_US * `DBWS_CLK_MHZ)
// ---------------------------------------------------------------
// register map: address bit 4 picks bank B, bits 3..0 the index
// ---------------------------------------------------------------
`define DBWS_BANK_BIT 4
`define DBWS_REG_CFG1 4'h0
`define DBWS_REG_CFG2 4'h1
`define DBWS_REG_CMD 4'h3
`define DBWS_REG_SEQ 4'h4
`define DBWS_CFG1_RST 8'h91
`define DBWS_CFG2_RST 8'h10
`define DBWS_CMDH_RST 7'h04
`define DBWS_SEQ_RST 8'h00
`define DBWS_STATUS_RST 1'b1
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DBWS_GRST_BIT 3
`define DBWS_OSCEN_BIT 0
`define DBWS_SEQ_ON_HI 7
`define DBWS_SEQ_ON_LO 4
`define DBWS_SEQ_OFF_HI 3
`define DBWS_SEQ_OFF_LO 1
`define DBWS_SEQ_SEL_BIT 0
`define DBWS_CMD_WR_BIT 7
`define DBWS_CMD_N_HI 6
`define DBWS_CMD_N_LO 5
`define DBWS_CMD_A_HI 4
`endif

// >>> core/dbws_pkg.sv
// dbws_pkg: types of the dual bank wake sequencer
// assumes: constants come from dbws_cfg.svh
package dbws_pkg;
  // operating state; also used for the free-running schedule
  typedef enum logic [1:0] {ST_OFF, ST_A, ST_B} dbws_state_t;
  // first configuration register, bit 7 down to bit 0
  typedef struct packed {
    logic lo_band_hi;
    logic lo_band_lo;
    logic carrier_band_hi;
    logic carrier_band_lo;
    logic global_reset;
    logic switch_polarity;
    logic low_voltage_detect_enable;
    logic data_clock_output_enable;
  } dbws_cfg1_t;
  // one register bank
  typedef struct packed {
    dbws_cfg1_t cfg1;
    logic [7:0] cfg2;
    logic [6:0] cmd_hi;
    logic [7:0] seq;
  } dbws_bank_t;
endpackage : dbws_pkg

// >>> core/dbws_timer.sv
// dbws_timer: counts a duration of whole ticks on the system clock
// assumes: restart_i comes from logic on the same clock
`timescale 1ns/10ps
`include "dbws_cfg.svh"
module dbws_timer
  import dbws_pkg::*;
#(
  parameter int TICK_CYC = `DBWS_TICK_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic restart_i,
  input wire logic [3:0] units_i,
  output logic done_o
);
  logic [15:0] pre;
  logic [15:0] next_pre;
  logic [3:0] unit;
  logic [3:0] next_unit;
  logic next_done;

  // -------------------------------------------------------------
  // tick prescaler and tick counter
  // -------------------------------------------------------------
  // a zero count still lasts one tick so no state can vanish;
  // done is not gated by restart, the caller restarts on done
  always_comb begin
    next_pre = 16'(pre + 16'h0001);
    next_unit = unit;
    next_done = 1'b0;
    if (pre == 16'(TICK_CYC - 1)) begin
      next_pre = 16'h0000;
      if (4'(unit + 4'h1) >= units_i) begin
        next_done = 1'b1;
        next_unit = 4'h0;
      end else begin
        next_unit = 4'(unit + 4'h1);
      end
    end
    if (restart_i) begin
      next_pre = 16'h0000;
      next_unit = 4'h0;
    end
  end

  // done marks the last cycle of the duration, so the state changes
  // on the tick boundary; a registered done would add a cycle per state
  assign done_o = next_done;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pre <= 16'h0000;
      unit <= 4'h0;
    end else if (ce_i) begin
      pre <= next_pre;
      unit <= next_unit;
    end
  end
endmodule : dbws_timer

// >>> tb/dbws_host.sv
// dbws_host: microcontroller model driving the wake pin and serial port
// assumes: clock_i is the system clock; every line moves at its fall
`timescale 1ns/10ps
module dbws_host (
  input wire logic clock_i,
  input wire logic spi_miso_i,
  output logic wake_pin_o,
  output logic wake_float_o,
  output logic cfg_sel_n_o,
  output logic spi_sclk_o,
  output logic spi_mosi_o
);
  logic level;
  logic junk;
  // ---------------------------------------------------------------
  // wake pin
  // ---------------------------------------------------------------
  // a released port carries no level, so show a changing pattern
  assign wake_pin_o = wake_float_o ? junk : level;
  always @(negedge clock_i) begin
    junk <= ~junk;
  end
  initial begin
    level = 1'b0;
    junk = 1'b0;
    wake_float_o = 1'b0;
    cfg_sel_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_mosi_o = 1'b0;
  end
  task automatic fall(input int n);
    repeat (n) @(negedge clock_i);
  endtask : fall
  // port driven (pin mode) or floating (oscillator in charge)
  task automatic drive_wake(input logic lvl, input logic flt);
    level = lvl;
    wake_float_o = flt;
  endtask : drive_wake
  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  // 4 clocks per phase keeps above the 3-clock minimum of the sync
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi_o = tx[i];
      fall(4);
      rx[i] = spi_miso_i;
      spi_sclk_o = 1'b1;
      fall(4);
      spi_sclk_o = 1'b0;
    end
  endtask : byte_io
  // whole access: command, n data bytes, then select high
  task automatic access(input logic [7:0] cmd, input int n,
                        inout logic [7:0] data [8]);
    logic [7:0] dummy;
    cfg_sel_n_o = 1'b0;
    fall(4);
    byte_io(cmd, dummy);
    for (int k = 0; k < n; k++) begin
      byte_io(data[k], data[k]);
    end
    fall(4);
    cfg_sel_n_o = 1'b1;
    spi_mosi_o = ~spi_mosi_o;
    fall(4);
  endtask : access
endmodule : dbws_host

// >>> tb/dual_bank_wake_sequencer_tb.sv
// dual_bank_wake_sequencer_tb: self-checking bench of dbws_main
// assumes: dbws_host plays the microcontroller; msg_rx_i is driven here
`timescale 1ns/10ps
module dual_bank_wake_sequencer_tb;
  import dbws_pkg::*;
  localparam int TICK = 4;
  logic clock_i, rst_i, ce_i, msg_rx_i;
  logic wake_pin, wake_float, sel_n, sclk, mosi, miso;
  dbws_state_t dev_state;
  logic bank_status;
  dbws_cfg1_t band_ctrl;
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] buf8 [8];
  dbws_main #(.TICK_CYC(TICK)) dbws_main_inst (.clock_i(clock_i),
    .rst_i(rst_i), .ce_i(ce_i), .wake_pin_i(wake_pin),
    .wake_float_i(wake_float), .cfg_sel_n_i(sel_n), .spi_sclk_i(sclk),
    .spi_mosi_i(mosi), .msg_rx_i(msg_rx_i), .spi_miso_o(miso),
    .dev_state_o(dev_state), .bank_status_o(bank_status),
    .band_ctrl_o(band_ctrl));
  dbws_host dbws_host_inst (.clock_i(clock_i), .spi_miso_i(miso),
    .wake_pin_o(wake_pin), .wake_float_o(wake_float),
    .cfg_sel_n_o(sel_n), .spi_sclk_o(sclk), .spi_mosi_o(mosi));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [4:0] a, input logic [1:0] nc);
    dbws_host_inst.access({1'b0, nc, a}, 1 << nc, buf8);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    buf8[0] = v;
    dbws_host_inst.access({3'b100, a}, 1, buf8);
  endtask : wr
  // pin reaches dev_state 3 clocks after its edge; one spare clock
  task automatic pin(input logic lvl, input logic flt);
    dbws_host_inst.drive_wake(lvl, flt);
    dbws_host_inst.fall(4);
  endtask : pin
  task automatic st(input dbws_state_t s, input logic b);
    check("state", dev_state, s);
    check("status", bank_status, b);
  endtask : st
  // wait for state s, then count how many clocks it lasts
  task automatic seg(input dbws_state_t s, input int len, input logic b);
    int n;
    n = 0;
    while (dev_state !== s && n < 200) begin
      dbws_host_inst.fall(1);
      n++;
    end
    st(s, b);
    n = 0;
    while (dev_state === s && n < 200) begin
      dbws_host_inst.fall(1);
      n++;
    end
    check("len", n[7:0], len[7:0]);
  endtask : seg
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_reset();
    check("band", band_ctrl, 8'h91);
    rd(5'h00, 2'b11);
    check("cfg1", buf8[0], 8'h91);
    check("cfg2", buf8[1], 8'h10);
    check("gap", buf8[2], 8'h00);
    check("cmd", buf8[3], 8'h09);
    check("seq", buf8[4], 8'h00);
    rd(5'h13, 2'b00);
    check("cmd_b", buf8[0], 8'h09);
  endtask : s_reset
  task automatic s_regs();
    wr(5'h00, 8'ha5);
    wr(5'h01, 8'h54);
    rd(5'h00, 2'b01);
    check("cfg1_wr", buf8[0], 8'ha5);
    check("cfg2_wr", buf8[1], 8'h54);
    check("band_wr", band_ctrl, 8'ha5);
    wr(5'h00, 8'h08);
    rd(5'h00, 2'b01);
    check("grst_cfg1", buf8[0], 8'h91);
    check("grst_cfg2", buf8[1], 8'h10);
  endtask : s_regs
  task automatic s_pin_single();
    pin(1'b1, 1'b0);
    st(ST_A, 1'b1);
    msg_rx_i = 1'b1;
    pin(1'b0, 1'b0);
    pin(1'b0, 1'b0);
    st(ST_A, 1'b1);
    msg_rx_i = 1'b0;
    dbws_host_inst.fall(4);
    check("off", dev_state, ST_OFF);
    wr(5'h14, 8'h01);  // bank B alone selected
    pin(1'b1, 1'b0);
    st(ST_B, 1'b0);
    pin(1'b0, 1'b0);
    check("off_b", dev_state, ST_OFF);
  endtask : s_pin_single
  task automatic s_pin_alt();
    wr(5'h04, 8'h01);  // both banks: alternate on each wakeup
    pin(1'b1, 1'b0);
    st(ST_A, 1'b1);
    pin(1'b0, 1'b0);
    st(ST_OFF, 1'b0);
    pin(1'b1, 1'b0);
    st(ST_B, 1'b0);
    pin(1'b0, 1'b0);
    st(ST_OFF, 1'b1);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    rd(5'h03, 2'b00);
    check("cmd_st0", buf8[0], 8'h08);
    pin(1'b1, 1'b0);
    st(ST_A, 1'b1);
    pin(1'b0, 1'b0);
  endtask : s_pin_alt
  task automatic s_osc();
    int n;
    wr(5'h04, 8'h15);  // A on 1 tick, off 2 ticks, selected
    wr(5'h14, 8'h31);  // B on 3 ticks, selected
    wr(5'h01, 8'h11);  // oscillator enabled
    pin(1'b0, 1'b1);
    seg(ST_OFF, 2 * TICK, 1'b1);
    seg(ST_A, 1 * TICK, 1'b1);
    seg(ST_B, 3 * TICK, 1'b0);
    seg(ST_OFF, 2 * TICK, 1'b1);
    n = 0;
    while (dev_state !== ST_B && n < 200) begin
      dbws_host_inst.fall(1);
      n++;
    end
    pin(1'b1, 1'b0);
    dbws_host_inst.fall(40);
    st(ST_B, 1'b0);
    pin(1'b0, 1'b0);
    check("ovr_off", dev_state, ST_OFF);
  endtask : s_osc
  // clock enable low freezes the schedule; a mid-run reset reloads
  task automatic s_freeze();
    int n;
    logic b;
    n = 0;
    pin(1'b0, 1'b1);
    while (dev_state !== ST_OFF && n < 200) begin
      dbws_host_inst.fall(1);
      n++;
    end
    while (dev_state !== ST_B && n < 400) begin
      dbws_host_inst.fall(1);
      n++;
    end
    b = bank_status;
    ce_i = 1'b0;
    dbws_host_inst.fall(20);
    check("frz_state", dev_state, ST_B);
    check("frz_status", bank_status, b);
    ce_i = 1'b1;
    n = 0;
    while (dev_state === ST_B && n < 200) begin
      dbws_host_inst.fall(1);
      n++;
    end
    check("frz_len", n[7:0], 8'(3 * TICK));
    pin(1'b0, 1'b0);
    rst_i = 1'b1;
    dbws_host_inst.fall(2);
    st(ST_OFF, 1'b1);
    check("band_rst", band_ctrl, 8'h91);
    rst_i = 1'b0;
    dbws_host_inst.fall(4);
    rd(5'h03, 2'b01);
    check("cmd_rst", buf8[0], 8'h09);
    check("seq_rst", buf8[1], 8'h00);
  endtask : s_freeze
  // ---------------------------------------------------------------
  // clock, sequence and verdict
  // ---------------------------------------------------------------
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    msg_rx_i = 1'b0;
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    dbws_host_inst.fall(4);
    s_reset();
    s_regs();
    s_pin_single();
    s_pin_alt();
    s_osc();
    s_freeze();
    summarize();
  end
  // the whole run needs well under 10000 clocks
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
endmodule : dual_bank_wake_sequencer_tb
